// ===== inc/lsc_pkg.sv
// Package for the LCD system configuration register block.
// Assumes a single 50 MHz clock and an 8-bit register path.
package lsc_pkg;
    localparam logic [15:0] MEMORY_CONFIGURATION_ADDR = 16'h8000;
    localparam logic [15:0] BLOCK_ONE_START_ADDR = 16'h800b;
    localparam logic [15:0] BLOCK_TWO_START_ADDR = 16'h800e;
    localparam logic [15:0] BLOCK_THREE_START_ADDR = 16'h8011;
    localparam logic [15:0] BLOCK_FOUR_START_ADDR = 16'h8013;
    localparam logic [15:0] PIXEL_SCROLL_ADDR = 16'h801b;
    localparam logic [15:0] FRAME_HEIGHT_ADDR = 16'h8005;
    localparam logic [7:0] CONFIG_RESET = 8'h10;
    localparam logic [7:0] CONFIG_WRITE_MASK = 8'h3f;
    localparam int BIT_SOURCE = 0;
    localparam int BIT_HEIGHT = 2;
    localparam int BIT_DUAL = 3;
    localparam int BIT_SHIFT_DIS = 5;
    localparam logic [2:0] SCROLL_MASK = 3'h7;
    localparam int CMD_PARAM_COUNT = 8;
    localparam logic [4:0] GLYPH_SHORT = 5'h08;
    localparam logic [4:0] GLYPH_TALL = 5'h10;
    // Host software register map
    localparam logic [3:0] HR_CTRL = 4'h0;
    localparam logic [3:0] HR_CONFIG = 4'h1;
    localparam logic [3:0] HR_HEIGHT = 4'h2;
    localparam logic [3:0] HR_STATUS = 4'h3;
    localparam logic [3:0] HR_SL1 = 4'h4;
    localparam logic [3:0] HR_SL2 = 4'h5;
    // Direct write: device register offset, then the data byte that sends it
    localparam logic [3:0] HR_RAW_ADDR = 4'h6;
    localparam logic [3:0] HR_RAW_DATA = 4'h7;
    localparam int CTRL_GO = 0;
    localparam int CTRL_INDIRECT = 1;
    localparam int CTRL_ORIGIN_FIX = 2;
    typedef enum logic [1:0] {
        LSC_IDLE = 2'b00,
        LSC_SEND = 2'b01,
        LSC_DONE = 2'b11
    } lsc_state_e;
endpackage

// ===== inc/lsc_if.sv
// Parallel link between host CPU logic and the LCD configuration device.
// Both ends share clk; the testbench drives clk.
`timescale 1ns/100ps
interface lsc_if (input wire logic clk);
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic indirect;
    logic cmd_param;
    modport device (input addr, wdata, wr, indirect, cmd_param);
    modport host (output addr, wdata, wr, indirect, cmd_param);
endinterface

// ===== verilog/lsc_scroll_calc.sv
// Scroll-line figures derived from the frame height and panel mode.
// Pure combinational; used by the host end.
`timescale 1ns/100ps
module lsc_scroll_calc (
    input wire logic [7:0] frame_height,
    input wire logic dual,
    input wire logic origin_fix,
    output logic [7:0] scroll_lines
);
    function automatic logic [7:0] half_lines(input logic [7:0] fh);
        logic [8:0] sum;
        sum = {1'b0, fh} + 9'h001;
        return 8'(sum[8:1] - 8'h01);
    endfunction
    always_comb begin
        if (dual) begin
            scroll_lines = half_lines(frame_height);
        end else if (origin_fix && frame_height != 8'hff) begin
            scroll_lines = frame_height + 8'h01;
        end else begin
            scroll_lines = frame_height;
        end
    end
endmodule

// ===== verilog/lsc_device.sv
// Device end: memory configuration register and what it steers.
// Assumes the host keeps reserved bits zero except bit 4, kept at 1, and legal scroll counts.
`timescale 1ns/100ps
module lsc_device (
    input wire logic clk,
    input wire logic reset_n,
    lsc_if.device link,
    input wire logic display_on_req,
    output logic [7:0] config_value,
    output logic display_enabled,
    output logic power_save,
    output logic timing_restart,
    output logic dual_panel,
    output logic [4:0] glyph_height,
    output logic user_glyph_source,
    output logic text_row_shift,
    output logic [2:0] text_pixel_shift,
    output logic [8:0] frame_lines,
    output logic [15:0] block_one_start,
    output logic [15:0] block_two_start,
    output logic [15:0] block_three_start,
    output logic [15:0] block_four_start
);
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] height;
        logic [2:0] scroll;
        logic [15:0] b1;
        logic [15:0] b2;
        logic [15:0] b3;
        logic [15:0] b4;
        logic disp;
        logic psave;
        logic restart;
        logic [2:0] pidx;
    } lsc_dev_s;

    lsc_dev_s st_q;
    lsc_dev_s st_d;

    // Byte address of a configure-command parameter or a direct write
    logic [15:0] eff_addr;

    function automatic logic [15:0] put_byte(input logic [15:0] w, input logic hi,
                                             input logic [7:0] b);
        return hi ? {b, w[7:0]} : {w[15:8], b};
    endfunction

    always_comb begin
        eff_addr = link.cmd_param
            ? lsc_pkg::MEMORY_CONFIGURATION_ADDR + {13'h0000, st_q.pidx}
            : link.addr;
        st_d = st_q;
        st_d.restart = 1'b0;
        if (display_on_req) begin
            st_d.disp = 1'b1;
        end
        if (link.wr) begin
            if (link.cmd_param) begin
                st_d.pidx = 3'(st_q.pidx + 3'h1);
            end
            case (eff_addr)
                lsc_pkg::MEMORY_CONFIGURATION_ADDR: begin
                    st_d.cfg = link.wdata & lsc_pkg::CONFIG_WRITE_MASK;
                    st_d.restart = 1'b1;
                    st_d.disp = 1'b0;
                    if (link.indirect) begin
                        st_d.psave = 1'b0;
                    end
                end
                lsc_pkg::FRAME_HEIGHT_ADDR: st_d.height = link.wdata;
                lsc_pkg::PIXEL_SCROLL_ADDR: st_d.scroll = link.wdata[2:0] & lsc_pkg::SCROLL_MASK;
                lsc_pkg::BLOCK_ONE_START_ADDR: st_d.b1 = put_byte(st_q.b1, 1'b0, link.wdata);
                16'h800c: st_d.b1 = put_byte(st_q.b1, 1'b1, link.wdata);
                lsc_pkg::BLOCK_TWO_START_ADDR: st_d.b2 = put_byte(st_q.b2, 1'b0, link.wdata);
                16'h800f: st_d.b2 = put_byte(st_q.b2, 1'b1, link.wdata);
                lsc_pkg::BLOCK_THREE_START_ADDR: st_d.b3 = put_byte(st_q.b3, 1'b0, link.wdata);
                16'h8012: st_d.b3 = put_byte(st_q.b3, 1'b1, link.wdata);
                lsc_pkg::BLOCK_FOUR_START_ADDR: st_d.b4 = put_byte(st_q.b4, 1'b0, link.wdata);
                16'h8014: st_d.b4 = put_byte(st_q.b4, 1'b1, link.wdata);
                default: ;
            endcase
        end
        if (!link.cmd_param) begin
            st_d.pidx = 3'h0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
            st_q.cfg <= lsc_pkg::CONFIG_RESET;
            st_q.psave <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign config_value = st_q.cfg;
    assign display_enabled = st_q.disp;
    assign power_save = st_q.psave;
    assign timing_restart = st_q.restart;
    assign dual_panel = st_q.cfg[lsc_pkg::BIT_DUAL];
    assign glyph_height = st_q.cfg[lsc_pkg::BIT_HEIGHT]
        ? lsc_pkg::GLYPH_TALL : lsc_pkg::GLYPH_SHORT;
    assign user_glyph_source = st_q.cfg[lsc_pkg::BIT_SOURCE];
    assign text_row_shift = !st_q.cfg[lsc_pkg::BIT_SHIFT_DIS];
    assign text_pixel_shift = st_q.scroll;
    assign frame_lines = {1'b0, st_q.height} + 9'h001;
    assign block_one_start = st_q.b1;
    assign block_two_start = st_q.b2;
    assign block_three_start = st_q.b3;
    assign block_four_start = st_q.cfg[lsc_pkg::BIT_DUAL] ? st_q.b4 : 16'h0000;
endmodule

// ===== verilog/lsc_host.sv
// Host end: software register port that issues configuration writes.
// Assumes the device accepts one write per cycle without waiting.
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
module lsc_host (
    input wire logic clk,
    input wire logic reset_n,
    lsc_if.host link,
    input wire logic [3:0] sw_addr,
    input wire logic [7:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [7:0] sw_rdata
);
    typedef struct packed {
        lsc_pkg::lsc_state_e state;
        logic [2:0] ctrl;
        logic [7:0] cfg;
        logic [7:0] height;
        logic [2:0] idx;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic cmd;
        logic [7:0] rdata;
        logic [7:0] raw_off;
        logic [7:0] raw_data;
        logic raw_go;
    } lsc_host_s;

    lsc_host_s st_q;
    lsc_host_s st_d;
    logic [7:0] sl_val;

    lsc_scroll_calc i_lsc_scroll_calc (
        .frame_height(st_q.height),
        .dual(st_q.cfg[lsc_pkg::BIT_DUAL]),
        .origin_fix(st_q.ctrl[lsc_pkg::CTRL_ORIGIN_FIX]),
        .scroll_lines(sl_val)
    );

    // Parameter byte for the configure command, index 0 is the config register
    function automatic logic [7:0] param_byte(input logic [2:0] i, input logic [7:0] c,
                                              input logic [7:0] h);
        if (i == 3'h0) begin
            return c & lsc_pkg::CONFIG_WRITE_MASK;
        end else if (i == 3'h5) begin
            return h;
        end
        return 8'h00;
    endfunction

    always_comb begin
        st_d = st_q;
        st_d.wr = 1'b0;
        st_d.rdata = 8'h00;
        if (sw_rd) begin
            case (sw_addr)
                lsc_pkg::HR_CTRL: st_d.rdata = {5'h00, st_q.ctrl};
                lsc_pkg::HR_CONFIG: st_d.rdata = st_q.cfg;
                lsc_pkg::HR_HEIGHT: st_d.rdata = st_q.height;
                lsc_pkg::HR_STATUS: st_d.rdata = {7'h00, st_q.state != lsc_pkg::LSC_IDLE};
                lsc_pkg::HR_SL1, lsc_pkg::HR_SL2: st_d.rdata = sl_val;
                default: st_d.rdata = 8'h00;
            endcase
        end
        if (sw_wr && st_q.state == lsc_pkg::LSC_IDLE) begin
            case (sw_addr)
                lsc_pkg::HR_CTRL: st_d.ctrl = sw_wdata[2:0];
                // Reserved bit 4 is kept as 1 per its default; other reserved stay 0
                lsc_pkg::HR_CONFIG: st_d.cfg = (sw_wdata & 8'h2d) | 8'h10;
                lsc_pkg::HR_HEIGHT: st_d.height = sw_wdata;
                lsc_pkg::HR_RAW_ADDR: st_d.raw_off = sw_wdata;
                lsc_pkg::HR_RAW_DATA: st_d.raw_data = sw_wdata;
                default: ;
            endcase
        end
        case (st_q.state)
            lsc_pkg::LSC_IDLE: begin
                st_d.cmd = 1'b0;
                if (st_q.raw_go) begin
                    // One plain write to a device register, no command framing
                    st_d.raw_go = 1'b0;
                    st_d.wr = 1'b1;
                    st_d.addr = lsc_pkg::MEMORY_CONFIGURATION_ADDR + {8'h00, st_q.raw_off};
                    st_d.wdata = st_q.raw_data;
                end else if (st_q.ctrl[lsc_pkg::CTRL_GO]) begin
                    st_d.ctrl[lsc_pkg::CTRL_GO] = 1'b0;
                    st_d.idx = 3'h0;
                    st_d.state = lsc_pkg::LSC_SEND;
                end
            end
            lsc_pkg::LSC_SEND: begin
                st_d.wr = 1'b1;
                st_d.cmd = st_q.ctrl[lsc_pkg::CTRL_INDIRECT];
                st_d.addr = lsc_pkg::MEMORY_CONFIGURATION_ADDR + {13'h0000, st_q.idx};
                st_d.wdata = param_byte(st_q.idx, st_q.cfg, st_q.height);
                st_d.idx = 3'(st_q.idx + 3'h1);
                if (st_q.idx == 3'(lsc_pkg::CMD_PARAM_COUNT - 1)) begin
                    st_d.state = lsc_pkg::LSC_DONE;
                end
            end
            lsc_pkg::LSC_DONE: st_d.state = lsc_pkg::LSC_IDLE;
            default: st_d.state = lsc_pkg::LSC_IDLE;
        endcase
        // A new direct write wins over the clear of the one being sent
        if (sw_wr && st_q.state == lsc_pkg::LSC_IDLE && sw_addr == lsc_pkg::HR_RAW_DATA) begin
            st_d.raw_go = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
            st_q.state <= lsc_pkg::LSC_IDLE;
            st_q.cfg <= lsc_pkg::CONFIG_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign link.addr = st_q.addr;
    assign link.wdata = st_q.wdata;
    assign link.wr = st_q.wr;
    assign link.cmd_param = st_q.cmd;
    assign link.indirect = st_q.ctrl[lsc_pkg::CTRL_INDIRECT];
    assign sw_rdata = st_q.rdata;
endmodule

// ===== test/lsc_chk.sv
// Checker for the configuration link and the device outputs it steers.
// Assumes it sits beside lsc_if, fed by name from the link and device ports.
`timescale 1ns/100ps
module lsc_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic indirect,
    input wire logic [7:0] config_value,
    input wire logic display_enabled,
    input wire logic power_save,
    input wire logic timing_restart,
    input wire logic dual_panel,
    input wire logic [4:0] glyph_height,
    input wire logic user_glyph_source,
    input wire logic text_row_shift,
    input wire logic [15:0] block_four_start
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_cfg_wr;
        wr && addr == lsc_pkg::MEMORY_CONFIGURATION_ADDR;
    endsequence
    sequence s_ind_cfg_wr;
        wr && indirect && addr == lsc_pkg::MEMORY_CONFIGURATION_ADDR;
    endsequence
    sequence s_restart_pulse;
        timing_restart ##1 !timing_restart;
    endsequence
    property p_restart;
        s_cfg_wr |=> s_restart_pulse;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart pulse");
    property p_blank;
        s_cfg_wr |=> !display_enabled;
    endproperty
    a_blank: assert property (p_blank) else $error("display not blanked");
    property p_wake;
        s_ind_cfg_wr |=> !power_save;
    endproperty
    a_wake: assert property (p_wake) else $error("power save kept");
    property p_load;
        s_cfg_wr |=> config_value == ($past(wdata) & 8'h3f);
    endproperty
    a_load: assert property (p_load) else $error("config load wrong");
    property p_dual;
        dual_panel == config_value[3];
    endproperty
    a_dual: assert property (p_dual) else $error("panel mode wrong");
    property p_shift;
        text_row_shift == !config_value[5];
    endproperty
    a_shift: assert property (p_shift) else $error("row shift wrong");
    property p_height;
        glyph_height == (config_value[2] ? 5'h10 : 5'h08);
    endproperty
    a_height: assert property (p_height) else $error("glyph height wrong");
    property p_source;
        user_glyph_source == config_value[0];
    endproperty
    a_source: assert property (p_source) else $error("glyph source wrong");
    property p_block4;
        !dual_panel |-> block_four_start == 16'h0000;
    endproperty
    a_block4: assert property (p_block4) else $error("block four used");
endmodule

// ===== test/lcd_system_config_register_tb.sv
// Testbench: host end and device end joined by lsc_if, driven from the software port.
// Assumes the design package and interface are compiled first.
`timescale 1ns/100ps
module lcd_system_config_register_tb;
    logic clk;
    logic reset_n;
    logic display_on_req;
    logic [3:0] sw_addr;
    logic [7:0] sw_wdata;
    logic sw_wr;
    logic sw_rd;
    logic [7:0] sw_rdata;
    logic [7:0] config_value;
    logic display_enabled;
    logic power_save;
    logic timing_restart;
    logic dual_panel;
    logic [4:0] glyph_height;
    logic user_glyph_source;
    logic text_row_shift;
    logic [8:0] frame_lines;
    logic [2:0] text_pixel_shift;
    logic [15:0] block_one_start;
    logic [15:0] block_two_start;
    logic [15:0] block_three_start;
    logic [15:0] block_four_start;
    logic rd_d;
    logic [7:0] exp_q[$];
    int n_fail;
    int compares;
    int seed;
    lsc_if link (.clk(clk));
    lsc_host i_lsc_host (.clk(clk), .reset_n(reset_n), .link(link), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
    lsc_device i_lsc_device (.clk(clk), .reset_n(reset_n), .link(link),
        .display_on_req(display_on_req), .config_value(config_value),
        .display_enabled(display_enabled), .power_save(power_save),
        .timing_restart(timing_restart), .dual_panel(dual_panel), .glyph_height(glyph_height),
        .user_glyph_source(user_glyph_source), .text_row_shift(text_row_shift),
        .text_pixel_shift(text_pixel_shift), .frame_lines(frame_lines),
        .block_one_start(block_one_start), .block_two_start(block_two_start),
        .block_three_start(block_three_start), .block_four_start(block_four_start));
    lsc_chk i_lsc_chk (.clk(clk), .reset_n(reset_n), .addr(link.addr), .wdata(link.wdata),
        .wr(link.wr), .indirect(link.indirect), .config_value(config_value),
        .display_enabled(display_enabled), .power_save(power_save),
        .timing_restart(timing_restart), .dual_panel(dual_panel), .glyph_height(glyph_height),
        .user_glyph_source(user_glyph_source), .text_row_shift(text_row_shift),
        .block_four_start(block_four_start));
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic sw_raw(input logic [15:0] a, input logic [7:0] d);
        sw_write(lsc_pkg::HR_RAW_ADDR, a[7:0]);
        sw_write(lsc_pkg::HR_RAW_DATA, d);
    endtask
    task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask
    task automatic sw_read(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        exp_q.push_back(exp);
        @(posedge clk);
        sw_rd <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Read data stand in the cycle after the read strobe
    always @(posedge clk) begin
        rd_d <= sw_rd;
        if (rd_d) begin
            check({1'b0, sw_rdata}, {1'b0, exp_q.pop_front()});
        end
    end
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #200000;
        n_fail++;
        end_of_test();
    end
    initial begin
        logic [7:0] cfg;
        logic [7:0] h;
        logic ps;
        int sl;
        int w;
        seed = 42004;
        {reset_n, display_on_req, sw_addr, sw_wdata, sw_wr, sw_rd} = '0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        ps = 1'b1;
        sw_read(lsc_pkg::HR_CONFIG, lsc_pkg::CONFIG_RESET);
        check(power_save, 1'b1);
        check(config_value, lsc_pkg::CONFIG_RESET);
        for (int k = 0; k < 8; k++) begin
            // Reserved bit 4 kept 1, other reserved bits kept zero, as by the host
            cfg = ($random(seed) & 8'h2d) | 8'h10;
            h = $random(seed);
            @(posedge clk);
            display_on_req <= 1'b1;
            @(posedge clk);
            display_on_req <= 1'b0;
            @(posedge clk);
            check(display_enabled, 1'b1);
            sw_write(lsc_pkg::HR_CONFIG, cfg);
            sw_write(lsc_pkg::HR_HEIGHT, h);
            sw_write(lsc_pkg::HR_CTRL, {5'h00, k[1], k[0], 1'b1});
            w = 0;
            while (timing_restart !== 1'b1 && w < 40) begin
                @(posedge clk);
                w++;
            end
            check(w < 40, 1'b1);
            repeat (12) @(posedge clk);
            if (k[0]) begin
                ps = 1'b0;
            end
            check(config_value, cfg);
            check(display_enabled, 1'b0);
            check(power_save, ps);
            check(frame_lines, {1'b0, h} + 9'h001);
            if (cfg[3]) begin
                sl = (int'(h) + 1) / 2 - 1;
            end else begin
                sl = int'(h) + int'(k[1] && h != 8'hff);
            end
            sw_read(lsc_pkg::HR_CONFIG, cfg);
            sw_read(lsc_pkg::HR_HEIGHT, h);
            sw_read(lsc_pkg::HR_SL1, sl[7:0]);
            sw_read(lsc_pkg::HR_SL2, sl[7:0]);
            sw_read(lsc_pkg::HR_STATUS, 8'h00);
            sw_read(4'hf, 8'h00);
        end
        // Direct writes: n/a bits, pixel scroll, block starts in both panel modes
        for (int k = 0; k < 4; k++) begin
            w = $random(seed);
            sw_raw(lsc_pkg::MEMORY_CONFIGURATION_ADDR, {4'hd, k[0], 3'h0});
            sw_raw(lsc_pkg::PIXEL_SCROLL_ADDR, w[7:0]);
            sw_raw(lsc_pkg::BLOCK_ONE_START_ADDR, w[7:0]);
            sw_raw(lsc_pkg::BLOCK_ONE_START_ADDR + 16'h0001, w[15:8]);
            sw_raw(lsc_pkg::BLOCK_TWO_START_ADDR, w[23:16]);
            sw_raw(lsc_pkg::BLOCK_TWO_START_ADDR + 16'h0001, w[31:24]);
            sw_raw(lsc_pkg::BLOCK_THREE_START_ADDR, w[15:8]);
            sw_raw(lsc_pkg::BLOCK_THREE_START_ADDR + 16'h0001, w[7:0]);
            sw_raw(lsc_pkg::BLOCK_FOUR_START_ADDR, w[31:24]);
            sw_raw(lsc_pkg::BLOCK_FOUR_START_ADDR + 16'h0001, w[23:16]);
            repeat (3) @(posedge clk);
            check(config_value, {4'h1, k[0], 3'h0});
            check(dual_panel, k[0]);
            check(display_enabled, 1'b0);
            check(text_pixel_shift, w[2:0]);
            check_word(block_one_start, w[15:0]);
            check_word(block_two_start, w[31:16]);
            check_word(block_three_start, {w[7:0], w[15:8]});
            check_word(block_four_start, k[0] ? {w[23:16], w[31:24]} : 16'h0000);
        end
        repeat (3) @(posedge clk);
        end_of_test();
    end
endmodule
